//--- hdl/sdc_ctrl.sv
// Purpose: Sigma-delta converter control, sampling clock, result and event path
// Assumes: APB slave at 125 MHz; modulator bit sampled on sample strobe
// Notes:   Analog selections leave as levels; result bytes update together
//
// Summary of operation
// - Input gain code scales modulator input
// - Reference gain bit halves reference
// - Four-bit signed DC offset in eighths
// - Comb filters stream into 24-bit result
// - One result per selected oversampling ratio
// - Sampling clock from high-speed clock, selectable
// - Result readable as three bytes
// - Results are two's complement
// - New result raises interrupt event
// - Second and third order comb supported
// - Ratio code picks comb order and limits
// - Control bit 7 enables converter
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Modulator
  input  wire logic              mod_bit,
  output logic                   converter_sampling_clock,
  output sdc_pkg::sdc_ana_t      ana,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    sdc_pkg::sdc_byte_t ctrl0;
    sdc_pkg::sdc_byte_t ctrl1;
    sdc_pkg::sdc_byte_t ctrl2;
    logic [23:0]        result;
    logic [1:0]         stat;
    logic [1:0]         mask;
    logic [7:0]         div_cnt;
    logic               sclk;
    logic               smp;
    logic               mbit;
    logic [31:0]        rdata;
  } sdc_st_t;

  sdc_st_t s_q, s_d;
  sdc_pkg::sdc_result_t cres;

  logic wr_acc, rd_acc, mapped;
  logic [7:0] div_top;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      sdc_pkg::OFS_CTRL0, sdc_pkg::OFS_CTRL1, sdc_pkg::OFS_CTRL2,
      sdc_pkg::OFS_RES_U, sdc_pkg::OFS_RES_M, sdc_pkg::OFS_RES_L,
      sdc_pkg::OFS_STAT,  sdc_pkg::OFS_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Half-period count: base from frequency select, times prescaler power
  always_comb begin
    logic [7:0] base;
    base = s_q.ctrl2[sdc_pkg::CTRL2_FSEL_BIT] ? sdc_pkg::DIV_SLOW
                                               : sdc_pkg::DIV_FAST;
    div_top = base << s_q.ctrl2[sdc_pkg::CTRL2_PRE_LSB +: 2];
  end

  always_comb begin
    logic run;
    s_d = s_q;
    s_d.smp = 1'b0;
    run = s_q.ctrl0[sdc_pkg::CTRL0_EN_BIT];
    // Sampling clock divider; stream bit taken on rising sample edge
    if (run) begin
      if (s_q.div_cnt + 8'd1 >= div_top) begin
        s_d.div_cnt = '0;
        s_d.sclk = !s_q.sclk;
        if (!s_q.sclk) begin
          s_d.smp = 1'b1;
          s_d.mbit = mod_bit;
        end
      end else begin
        s_d.div_cnt = s_q.div_cnt + 8'd1;
      end
    end else begin
      s_d.div_cnt = '0;
      s_d.sclk = 1'b0;
    end
    // Register writes; reserved control bits stay zero
    if (wr_acc) begin
      case (paddr)
        sdc_pkg::OFS_CTRL0: s_d.ctrl0 = pwdata[7:0] & 8'hFE;
        sdc_pkg::OFS_CTRL1: s_d.ctrl1 = pwdata[7:0] & 8'h47;
        sdc_pkg::OFS_CTRL2: s_d.ctrl2 = pwdata[7:0];
        sdc_pkg::OFS_STAT:  s_d.stat = s_q.stat & ~pwdata[1:0];
        sdc_pkg::OFS_MASK:  s_d.mask = pwdata[1:0];
        default: ;
      endcase
    end
    // Whole result latched in one cycle; byte reads that span a new result can mix
    if (cres.valid) begin
      s_d.result = cres.value;
      if (s_q.stat[sdc_pkg::STAT_DONE_BIT])
        s_d.stat[sdc_pkg::STAT_OVR_BIT] = 1'b1;
      s_d.stat[sdc_pkg::STAT_DONE_BIT] = 1'b1;
    end
    // Read data registered during setup
    if (rd_acc) begin
      case (paddr)
        sdc_pkg::OFS_CTRL0: s_d.rdata = {24'h0, s_q.ctrl0};
        sdc_pkg::OFS_CTRL1: s_d.rdata = {24'h0, s_q.ctrl1};
        sdc_pkg::OFS_CTRL2: s_d.rdata = {24'h0, s_q.ctrl2};
        sdc_pkg::OFS_RES_U: s_d.rdata = {24'h0, s_q.result[23:16]};
        sdc_pkg::OFS_RES_M: s_d.rdata = {24'h0, s_q.result[15:8]};
        sdc_pkg::OFS_RES_L: s_d.rdata = {24'h0, s_q.result[7:0]};
        sdc_pkg::OFS_STAT:  s_d.rdata = {30'h0, s_q.stat};
        sdc_pkg::OFS_MASK:  s_d.rdata = {30'h0, s_q.mask};
        default:            s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.ctrl0 <= sdc_pkg::CTRL0_RST;
      s_q.ctrl1 <= sdc_pkg::CTRL1_RST;
      s_q.ctrl2 <= sdc_pkg::CTRL2_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  sdc_comb #(
    .ACC_W (48)
  ) u_comb (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .run     (s_q.ctrl0[sdc_pkg::CTRL0_EN_BIT]),
    .osr_sel (s_q.ctrl0[sdc_pkg::CTRL0_OSR_LSB +: 3]),
    .smp     (s_q.smp),
    .bit_in  (s_q.mbit),
    .res     (cres)
  );

  // Analog selections driven straight from control registers
  always_comb begin
    logic [2:0] g;
    g = s_q.ctrl1[sdc_pkg::CTRL1_GAIN_LSB +: 3];
    ana.converter_en       = s_q.ctrl0[sdc_pkg::CTRL0_EN_BIT];
    ana.chopper_en         = s_q.ctrl0[sdc_pkg::CTRL0_CHOP_BIT];
    ana.auto_input_swap_en = s_q.ctrl0[sdc_pkg::CTRL0_SWAP_BIT];
    ana.reference_gain_sel = s_q.ctrl0[sdc_pkg::CTRL0_RGAIN_BIT];
    ana.input_gain_sel     = g;
    // Reserved gain codes flagged so the modulator holds its last gain
    ana.input_gain_valid   = (g >= 3'h1) && (g <= 3'h5);
    ana.dc_offset_sel      = s_q.ctrl2[sdc_pkg::CTRL2_DC_LSB +: 4];
    ana.common_mode_sel    = s_q.ctrl1[sdc_pkg::CTRL1_CMS_BIT];
    ana.supply_pulldown_en = s_q.ctrl2[sdc_pkg::CTRL2_PULL_BIT];
  end

  assign converter_sampling_clock = s_q.sclk;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_q.rdata;
  assign irq     = |(s_q.stat & s_q.mask);

endmodule
`default_nettype wire

//--- hdl/sdc_pkg.sv
// Purpose: Shared constants and types for the sigma-delta converter control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses; field positions are bit numbers
package sdc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_CTRL2  = 8'h08;
  localparam logic [7:0] OFS_RES_U  = 8'h0C;
  localparam logic [7:0] OFS_RES_M  = 8'h10;
  localparam logic [7:0] OFS_RES_L  = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1C;

  // Control 0 field positions
  localparam int CTRL0_EN_BIT    = 7;
  localparam int CTRL0_CHOP_BIT  = 6;
  localparam int CTRL0_SWAP_BIT  = 5;
  localparam int CTRL0_RGAIN_BIT = 4;
  localparam int CTRL0_OSR_LSB   = 1;
  // Control 1 field positions
  localparam int CTRL1_CMS_BIT   = 6;
  localparam int CTRL1_GAIN_LSB  = 0;
  // Control 2 field positions
  localparam int CTRL2_DC_LSB    = 0;
  localparam int CTRL2_FSEL_BIT  = 4;
  localparam int CTRL2_PRE_LSB   = 5;
  localparam int CTRL2_PULL_BIT  = 7;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h40;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // Status bit positions
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OVR_BIT  = 1;

  // Result limits per comb order
  localparam logic [23:0] LIM3_POS = 24'h03FFFF;
  localparam logic [23:0] LIM3_NEG = 24'hFC0000;
  localparam logic [23:0] LIM2_POS = 24'h038401;
  localparam logic [23:0] LIM2_NEG = 24'hFC7C00;

  // Sampling clock divider base counts
  localparam logic [7:0] DIV_FAST = 8'h01;
  localparam logic [7:0] DIV_SLOW = 8'h02;

  typedef logic [7:0] sdc_byte_t;

  // Analog control outputs toward the modulator
  typedef struct packed {
    logic       converter_en;
    logic       chopper_en;
    logic       auto_input_swap_en;
    logic       reference_gain_sel;
    logic [2:0] input_gain_sel;
    logic       input_gain_valid;
    logic [3:0] dc_offset_sel;
    logic       common_mode_sel;
    logic       supply_pulldown_en;
  } sdc_ana_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } sdc_result_t;

endpackage

//--- hdl/sdc_comb.sv
// Purpose: Comb decimation filter, third or second order, for a 1-bit stream
// Assumes: One stream bit per sample strobe
// Notes:   Output clipped to order-specific limits
`timescale 1ns/1ps
`default_nettype none
module sdc_comb #(
  parameter int ACC_W = 48
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  // Control
  input  wire logic               run,
  input  wire logic [2:0]         osr_sel,
  // Stream
  input  wire logic               smp,
  input  wire logic               bit_in,
  // Result
  output sdc_pkg::sdc_result_t    res
);

  // Elaboration check: narrower integrators would wrap at the largest ratio
  if (ACC_W < 48) begin : g_acc_chk
    $error("ACC_W too small for integrator growth");
  end

  typedef struct packed {
    logic [ACC_W-1:0] i1, i2, i3;
    logic [ACC_W-1:0] d1, d2, d3;
    logic [15:0]      cnt;
    logic             first;
    sdc_pkg::sdc_result_t out;
  } sdc_comb_st_t;

  sdc_comb_st_t s_q, s_d;

  logic [15:0] osr_n;
  logic        third;
  always_comb begin
    third = 1'b1;
    case (osr_sel)
      3'h0: osr_n = 16'd32;
      3'h1: osr_n = 16'd64;
      3'h2: osr_n = 16'd128;
      3'h3: osr_n = 16'd256;
      3'h4: begin osr_n = 16'd7680;  third = 1'b0; end
      3'h5: begin osr_n = 16'd15360; third = 1'b0; end
      3'h6: begin osr_n = 16'd30720; third = 1'b0; end
      default: begin osr_n = 16'd61440; third = 1'b0; end
    endcase
  end

  always_comb begin
    logic [ACC_W-1:0] x, c1, c2, c3, y, pos_l, neg_l;
    logic [ACC_W-1:0] scaled;
    s_d = s_q;
    s_d.out.valid = 1'b0;
    x = bit_in ? ACC_W'(1) : {ACC_W{1'b1}};
    c1 = '0; c2 = '0; c3 = '0; y = '0; scaled = '0;
    pos_l = '0; neg_l = '0;
    if (!run) begin
      s_d = '0;
      s_d.out.value = s_q.out.value;
    end else if (smp) begin
      s_d.i1 = s_q.i1 + x;
      s_d.i2 = s_q.i2 + s_d.i1;
      s_d.i3 = s_q.i3 + s_d.i2;
      s_d.cnt = s_q.cnt + 16'd1;
      if (s_d.cnt == osr_n) begin
        s_d.cnt = '0;
        c1 = (third ? s_d.i3 : s_d.i2) - s_q.d1;
        c2 = c1 - s_q.d2;
        c3 = c2 - s_q.d3;
        s_d.d1 = third ? s_d.i3 : s_d.i2;
        s_d.d2 = c1;
        s_d.d3 = c2;
        y = third ? c3 : c2;
        // Full scale near 2^19; second order lands at 0.88 of it, then clips
        case (osr_sel)
          3'h0: scaled = y;
          3'h1: scaled = y;
          3'h2: scaled = $signed(y) >>> 2;
          3'h3: scaled = $signed(y) >>> 5;
          3'h4: scaled = $signed(y) >>> 7;
          3'h5: scaled = $signed(y) >>> 9;
          3'h6: scaled = $signed(y) >>> 11;
          default: scaled = $signed(y) >>> 13;
        endcase
        if (osr_sel == 3'h0) scaled = {scaled[ACC_W-5:0], 4'h0};
        if (osr_sel == 3'h1) scaled = {scaled[ACC_W-2:0], 1'b0};
        pos_l = ACC_W'($signed(third ? sdc_pkg::LIM3_POS : sdc_pkg::LIM2_POS));
        neg_l = ACC_W'($signed(third ? sdc_pkg::LIM3_NEG : sdc_pkg::LIM2_NEG));
        if ($signed(scaled) > $signed(pos_l)) scaled = pos_l;
        if ($signed(scaled) < $signed(neg_l)) scaled = neg_l;
        // First decimation only primes the comb delays
        s_d.first = 1'b1;
        if (s_q.first) begin
          s_d.out.value = scaled[23:0];
          s_d.out.valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) s_q <= '0;
    else if (ce) s_q <= s_d;
  end

  assign res = s_q.out;

endmodule
`default_nettype wire

//--- bench/sdc_props.sv
// Purpose: Port checker for the converter control block
// Assumes: Only the top module ports are visible
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sdc_props (
  // Clock, reset, enable
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              ce,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  // Modulator and interrupt
  input wire logic              converter_sampling_clock,
  input wire sdc_pkg::sdc_ana_t ana,
  input wire logic              irq
);
  logic wr;
  assign wr = psel && penable && pwrite && ce;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_gain_code: assert property (ana.input_gain_valid == (ana.input_gain_sel inside {[1:5]}))
    else $error("gain validity wrong");
  a_ref_gain: assert property (wr && paddr == 8'h00 |=> ana.reference_gain_sel == $past(pwdata[4]))
    else $error("reference gain not taken");
  a_dc_offset: assert property (wr && paddr == 8'h08 |=> ana.dc_offset_sel == $past(pwdata[3:0]))
    else $error("offset not taken");
  a_conv_en: assert property (wr && paddr == 8'h00 |=> ana.converter_en == $past(pwdata[7]))
    else $error("enable not taken");
  a_cm_sel: assert property (wr && paddr == 8'h04 |=> ana.common_mode_sel == $past(pwdata[6]))
    else $error("common mode not taken");
  a_pull_dn: assert property (wr && paddr == 8'h08 |=> ana.supply_pulldown_en == $past(pwdata[7]))
    else $error("pull-down not taken");
  a_clk_idle: assert property (!ana.converter_en && !$past(ana.converter_en) |-> !converter_sampling_clock)
    else $error("sampling clock runs while off");
  a_clk_rise: assert property ($rose(converter_sampling_clock) |-> $past(ana.converter_en))
    else $error("sampling clock rose while off");
  a_irq_reset: assert property ($past(sys_rst) |-> !irq)
    else $error("interrupt high after reset");
  a_mask_off: assert property (wr && paddr == 8'h1C && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("masked interrupt high");
endmodule
bind sdc_ctrl sdc_props i_props (.sys_clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .converter_sampling_clock, .ana, .irq);
`default_nettype wire

//--- bench/sdc_src_model.sv
// Purpose: Stream source in place of the input multiplexer and modulator
// Assumes: Design samples the bit on the rising sampling clock
// Notes:   Full scale gives constant ones, else alternating bits
`timescale 1ns/1ps
`default_nettype none
module sdc_src_model (
  // Sampling clock and mode
  input  wire logic converter_sampling_clock,
  input  wire logic full_scale,
  // Stream
  output var logic  mod_bit
);
  initial mod_bit = 1'b0;
  // Falling edge keeps the bit steady at the sampling edge
  always @(negedge converter_sampling_clock) begin
    mod_bit <= full_scale ? 1'b1 : ~mod_bit;
  end
endmodule
`default_nettype wire

//--- bench/sdc_ctrl_test.sv
// Purpose: Register and conversion tests for the converter control block
// Assumes: No wait states needed but none assumed
// Notes:   Result values rely on clamping at full scale
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_test;
  logic              sys_clk, sys_rst, ce, psel, penable, pwrite;
  logic              pready, pslverr, mod_bit, csck, irq, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  sdc_pkg::sdc_ana_t ana;
  int                fail_count, total_checks, n;
  sdc_ctrl i_dut (.sys_clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .mod_bit, .converter_sampling_clock(csck), .ana, .irq);
  sdc_src_model i_src (.converter_sampling_clock(csck), .full_scale(1'b1), .mod_bit);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic chk_res(input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, sdc_pkg::OFS_RES_U + 8'(4 * i), 32'h0);
      chk(rd, 32'((v >> (16 - 8 * i)) & 24'hFF));
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i == 1) ? 32'h40 : 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, sdc_pkg::OFS_CTRL1, 32'h40 | i);
      chk(ana.input_gain_sel, i);
      chk(ana.input_gain_valid, i inside {[1:5]});
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, sdc_pkg::OFS_CTRL2, i);
      chk(ana.dc_offset_sel, i);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, sdc_pkg::OFS_CTRL0, 32'(i) << 4);
      chk(ana.reference_gain_sel, i);
    end
    // Swap first, chopper after
    apb(1'b1, sdc_pkg::OFS_CTRL0, 32'h20);
    apb(1'b1, sdc_pkg::OFS_CTRL0, 32'h60);
    chk({ana.chopper_en, ana.auto_input_swap_en}, 2'h3);
    ce <= 1'b0;
    apb(1'b1, sdc_pkg::OFS_CTRL2, 32'h3);
    ce <= 1'b1;
    apb(1'b0, sdc_pkg::OFS_CTRL2, 32'h0);
    chk(rd, 32'h0F);
    apb(1'b1, sdc_pkg::OFS_MASK, 32'h1);
    // Slowest sampling clock the divider offers: half period 2 << 3
    apb(1'b1, sdc_pkg::OFS_CTRL2, 32'hF0);
    apb(1'b1, sdc_pkg::OFS_CTRL1, 32'h42);
    apb(1'b1, sdc_pkg::OFS_CTRL0, 32'h80);
    wait_irq();
    chk(irq, 1'b1);
    apb(1'b1, sdc_pkg::OFS_STAT, 32'h3);
    wait_irq();
    chk(32'(n + 3), 32'(32 * 2 * (2 << 3)));
    chk_res(sdc_pkg::LIM3_POS);
    apb(1'b1, sdc_pkg::OFS_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, sdc_pkg::OFS_MASK, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, sdc_pkg::OFS_CTRL0, 32'h0);
    apb(1'b1, sdc_pkg::OFS_STAT, 32'h3);
    chk(irq, 1'b0);
    // Fast sampling clock keeps the long ratio inside the run budget
    apb(1'b1, sdc_pkg::OFS_CTRL2, 32'h80);
    apb(1'b1, sdc_pkg::OFS_CTRL0, 32'h88);
    wait_irq();
    chk(irq, 1'b1);
    chk_res(sdc_pkg::LIM2_POS);
    test_done();
  end
endmodule
`default_nettype wire
